// ==== rtl/tmwc_top.sv ====
/*
 Control register A and waveform output logic of an 8-bit timer: decode of
 the register port, mode decode, TOP choice, compare double buffering,
 overflow event and compare output pins for channels A and B.
 Assumes the counter, prescaler and compare buffer registers live outside
 and present a counter value with a one-cycle timer tick.
*/
// Notes on behaviour
// - Control register answers at 0x44 and at 0x24 by port access; resets to zero.
// - Nonzero channel A field hands pin to compare output, except PWM toggle without mode bit2; driver follows direction bit.
// - Nonzero channel B field hands pin to compare output; driver follows direction bit.
// - Non-PWM channel A: off, toggle, clear or set on match.
// - Non-PWM channel B: off, toggle, clear or set on match.
// - Fast PWM A: off, toggle only with mode bit2, clear/set on match, opposite at BOTTOM.
// - Fast PWM A with compare equal TOP and upper bit: ignore match, keep BOTTOM action.
// - Phase correct A: toggle only with bit2; clear up, set down, or opposite.
// - Phase correct A with compare equal TOP and upper bit: action at TOP.
// - Fast PWM B: off, reserved, non-inverting or inverting.
// - PWM B with compare equal TOP and upper bit: ignore match, act at TOP.
// - Phase correct B: off, reserved, clear up set down, or opposite.
// - Three-bit mode from bit2 plus two low bits; 4 and 6 reserved.
// - TOP is 0xFF in modes 0,1,3, channel A compare in 2,5,7.
// - Compare values load immediately, at TOP, or at BOTTOM by mode.
// - Overflow at MAX in 0,2,3, BOTTOM in 1,5, TOP in 7.
`timescale 1ns/100ps
`include "tmwc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// One compare output channel

module tmwc_chan
   import tmwc_pkg::*;
#(
   parameter bit CHAN_A = 1'b1
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  com,
   input  tmwc_class_t      cls,
   input  wire logic        wgm2,
   input  wire logic        match,
   input  wire logic        at_top,
   input  wire logic        at_bottom,
   input  wire logic        ocr_is_top,
   input  wire logic        down,
   output logic             oc
);
   logic next_oc;

   // Toggle is only offered to channel A in PWM, and only with mode bit2
   wire pwm     = (cls == CLS_FAST) || (cls == CLS_PC);
   wire tog_ok  = (com == `TMWC_COM_TOGGLE) && (!pwm || (CHAN_A && wgm2));
   wire special = pwm && com[1] && ocr_is_top;
   wire hit     = match && !special;
   // Channel B moves its BOTTOM action to TOP in the special case
   wire fast_edge = (!CHAN_A && special) ? at_top : at_bottom;

   // Next output level per class
   always_comb
   begin
      next_oc = oc;
      case (cls)
         CLS_NORMAL, CLS_CLR:
         begin
            if (match && com[1])
               next_oc = com[0];
            else if (match && tog_ok)
               next_oc = ~oc;
         end
         CLS_FAST:
         begin
            if (hit && com[1])
               next_oc = com[0];
            else if (hit && tog_ok)
               next_oc = ~oc;
            if (fast_edge && com[1])
               next_oc = ~com[0];
         end
         CLS_PC:
         begin
            if (hit && com[1])
               next_oc = down ? ~com[0] : com[0];
            else if (hit && tog_ok)
               next_oc = ~oc;
            if (special && at_top)
               next_oc = com[0];
         end
         default:
            next_oc = oc;
      endcase
   end

   // Output compare level
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         oc <= 1'b0;
      else
         oc <= next_oc;
   end
endmodule // tmwc_chan

////////////////////////////////////////////////////////////////////////////////
// Top level

module tmwc_top
   import tmwc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        io_access,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   input  wire logic        wave_mode_bit2,
   input  tmwc_cnt_t        cnt,
   input  wire logic [7:0]  chan_a_compare_buf,
   input  wire logic [7:0]  chan_b_compare_buf,
   input  wire logic        ddr_a,
   input  wire logic        ddr_b,
   input  wire logic        port_a,
   input  wire logic        port_b,
   output logic             chan_a_pin_out,
   output logic             chan_a_pin_oe,
   output logic             chan_b_pin_out,
   output logic             chan_b_pin_oe,
   output logic [7:0]       top_value,
   output tmwc_class_t      mode_class,
   output logic             overflow_flag_set
);
   tmwc_ctl_t   ctl;
   tmwc_class_t cls;
   logic [7:0]  chan_a_compare_value;
   logic [7:0]  chan_b_compare_value;
   logic [7:0]  next_top;
   logic        next_ovf;
   logic        chan_a_compare_out;
   logic        chan_b_compare_out;

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode; port access sits 0x20 below the data address
   wire [7:0] io_addr  = `TMWC_CTRL_OFFSET - `TMWC_IO_DELTA;
   wire       reg_hit  = io_access ? (reg_addr == io_addr)
                                   : (reg_addr == `TMWC_CTRL_OFFSET);
   wire       wr_hit   = reg_wr && reg_hit;
   wire       rd_hit   = reg_rd && reg_hit;
   wire [7:0] ctl_word = ctl;

   // Control register; unimplemented bits never store
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         ctl <= `TMWC_CTRL_RESET;
      else if (wr_hit)
         ctl <= reg_wdata & `TMWC_CTRL_WMASK;
   end

   // Read data is registered, zero when not addressed
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= rd_hit ? ctl_word : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode; reserved codes fall back to a non-PWM class so outputs stay sane
   wire [2:0] mode = {wave_mode_bit2, ctl.wgm_lo};

   always_comb
   begin
      case (mode)
         `TMWC_MODE_NORMAL, `TMWC_MODE_RSV4:    cls = CLS_NORMAL;
         `TMWC_MODE_CLR, `TMWC_MODE_RSV6:       cls = CLS_CLR;
         `TMWC_MODE_PC_MAX, `TMWC_MODE_PC_OCR:  cls = CLS_PC;
         `TMWC_MODE_FAST, `TMWC_MODE_FAST_OCR:  cls = CLS_FAST;
         default:                               cls = CLS_NORMAL;
      endcase
   end

   // TOP source and counter events
   wire top_is_ocr = (mode == `TMWC_MODE_CLR) || (mode == `TMWC_MODE_PC_OCR)
                     || (mode == `TMWC_MODE_FAST_OCR);
   assign next_top = top_is_ocr ? chan_a_compare_value : `TMWC_MAX;
   wire at_top    = cnt.tick && (cnt.value == next_top);
   wire at_bottom = cnt.tick && (cnt.value == `TMWC_BOTTOM);
   wire at_max    = cnt.tick && (cnt.value == `TMWC_MAX);
   wire match_a   = cnt.tick && (cnt.value == chan_a_compare_value);
   wire match_b   = cnt.tick && (cnt.value == chan_b_compare_value);

   // Overflow point by mode
   always_comb
   begin
      case (mode)
         `TMWC_MODE_NORMAL, `TMWC_MODE_CLR, `TMWC_MODE_FAST:
            next_ovf = at_max;
         `TMWC_MODE_PC_MAX, `TMWC_MODE_PC_OCR:
            next_ovf = at_bottom;
         `TMWC_MODE_FAST_OCR:
            next_ovf = at_top;
         default:
            next_ovf = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare double buffering: PWM loads only at a period edge to avoid glitches
   wire load_cmp = (cls == CLS_NORMAL) || (cls == CLS_CLR)
                   || ((cls == CLS_PC) && at_top)
                   || ((cls == CLS_FAST) && at_bottom);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         chan_a_compare_value <= 8'h00;
         chan_b_compare_value <= 8'h00;
      end
      else if (load_cmp)
      begin
         chan_a_compare_value <= chan_a_compare_buf;
         chan_b_compare_value <= chan_b_compare_buf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare output channels
   tmwc_chan #(.CHAN_A(1'b1)) u_chan_a (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .com        (ctl.com_a),
      .cls        (cls),
      .wgm2       (wave_mode_bit2),
      .match      (match_a),
      .at_top     (at_top),
      .at_bottom  (at_bottom),
      .ocr_is_top (chan_a_compare_value == next_top),
      .down       (cnt.down),
      .oc         (chan_a_compare_out)
   );

   tmwc_chan #(.CHAN_A(1'b0)) u_chan_b (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .com        (ctl.com_b),
      .cls        (cls),
      .wgm2       (wave_mode_bit2),
      .match      (match_b),
      .at_top     (at_top),
      .at_bottom  (at_bottom),
      .ocr_is_top (chan_b_compare_value == next_top),
      .down       (cnt.down),
      .oc         (chan_b_compare_out)
   );

   // Pin mux: a nonzero field takes the pin, except channel A's PWM toggle code without mode bit2,
   // which leaves the pin to port logic; driver always follows direction
   wire pwm_cls = (cls == CLS_FAST) || (cls == CLS_PC);
   wire a_owns = (ctl.com_a != `TMWC_COM_OFF)
                 && !(pwm_cls && (ctl.com_a == `TMWC_COM_TOGGLE) && !wave_mode_bit2);
   wire b_owns = (ctl.com_b != `TMWC_COM_OFF);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         chan_a_pin_out    <= 1'b0;
         chan_a_pin_oe     <= 1'b0;
         chan_b_pin_out    <= 1'b0;
         chan_b_pin_oe     <= 1'b0;
         top_value         <= `TMWC_MAX;
         mode_class        <= CLS_NORMAL;
         overflow_flag_set <= 1'b0;
      end
      else
      begin
         chan_a_pin_out    <= a_owns ? chan_a_compare_out : port_a;
         chan_a_pin_oe     <= ddr_a;
         chan_b_pin_out    <= b_owns ? chan_b_compare_out : port_b;
         chan_b_pin_oe     <= ddr_b;
         top_value         <= next_top;
         mode_class        <= cls;
         overflow_flag_set <= next_ovf;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   reset_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (ctl_word == 8'h00))
      else $error("control register not zero after reset");

   io_alias_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && io_access && reg_addr == 8'h24) |=> (ctl_word == ($past(reg_wdata) & 8'hf3)))
      else $error("port alias write not stored or reserved bits kept");

   pin_a_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctl.com_a[1] || (ctl.com_a[0] && (wave_mode_bit2 || cls == CLS_NORMAL || cls == CLS_CLR)))
      |=> (chan_a_pin_out == $past(chan_a_compare_out) && chan_a_pin_oe == $past(ddr_a)))
      else $error("channel A pin not owned by compare output");

   pin_b_port_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ctl.com_b == 2'h0) |=> (chan_b_pin_out == $past(port_b)))
      else $error("channel B pin not returned to port logic");

   toggle_a_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cls == CLS_CLR && ctl.com_a == 2'h1 && match_a)
      |=> (chan_a_compare_out != $past(chan_a_compare_out)))
      else $error("channel A did not toggle on match");

   clear_b_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cls == CLS_NORMAL && ctl.com_b == 2'h2 && match_b) |=> !chan_b_compare_out)
      else $error("channel B not cleared on match");

   fast_bottom_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cls == CLS_FAST && ctl.com_a == 2'h2 && at_bottom) |=> chan_a_compare_out)
      else $error("channel A not set at bottom");

   fast_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cls == CLS_FAST && ctl.com_a[1] && chan_a_compare_value == next_top
       && match_a && !at_bottom) |=> $stable(chan_a_compare_out))
      else $error("channel A match not ignored at top");

   fast_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (cls == CLS_FAST && !at_bottom) |=> $stable(chan_a_compare_value))
      else $error("compare value loaded away from bottom");

   ovf_max_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (mode == 3'h0 && at_max) |=> overflow_flag_set ##1 !overflow_flag_set)
      else $error("overflow not a pulse at max");
endmodule // tmwc_top

// ==== rtl/tmwc_defines.svh ====
/*
 Offsets, write mask, reset values and waveform mode codes of the timer
 waveform mode control block. Assumes inclusion by bare name from rtl/.
*/
`ifndef TMWC_DEFINES_SVH
`define TMWC_DEFINES_SVH
`define TMWC_CTRL_OFFSET  8'h44
`define TMWC_IO_DELTA     8'h20
`define TMWC_CTRL_RESET   8'h00
`define TMWC_CTRL_WMASK   8'hf3
`define TMWC_MAX          8'hff
`define TMWC_BOTTOM       8'h00
`define TMWC_COM_OFF      2'h0
`define TMWC_COM_TOGGLE   2'h1
`define TMWC_MODE_NORMAL  3'h0
`define TMWC_MODE_PC_MAX  3'h1
`define TMWC_MODE_CLR     3'h2
`define TMWC_MODE_FAST    3'h3
`define TMWC_MODE_RSV4    3'h4
`define TMWC_MODE_PC_OCR  3'h5
`define TMWC_MODE_RSV6    3'h6
`define TMWC_MODE_FAST_OCR 3'h7
`endif

// ==== rtl/tmwc_pkg.sv ====
/*
 Types of the timer waveform mode control block.
 Assumes the counter and the compare buffers sit outside this block.
*/
package tmwc_pkg;
   // Operating class decoded from the three mode bits
   typedef enum logic [3:0] {
      CLS_NORMAL = 4'b0001,
      CLS_CLR    = 4'b0010,
      CLS_FAST   = 4'b0100,
      CLS_PC     = 4'b1000
   } tmwc_class_t;
   // Control register A layout
   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] unused;
      logic [1:0] wgm_lo;
   } tmwc_ctl_t;
   // Counter state seen from the outside counter
   typedef struct packed {
      logic       tick;
      logic       down;
      logic [7:0] value;
   } tmwc_cnt_t;
endpackage

// ==== sim/tmwc_top_bench.sv ====
/*
 Self-checking bench of the timer waveform control block: register port,
 mode decode, TOP choice, compare loading, overflow event and pins.
 Assumes tmwc_pkg and tmwc_top are compiled first; no partner model.
*/
`timescale 1ns/100ps

module tmwc_top_bench
   import tmwc_pkg::*;
;
   logic        sys_clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic        io_access;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        wave_mode_bit2;
   tmwc_cnt_t   cnt;
   logic [7:0]  cmp_a;
   logic [7:0]  cmp_b;
   logic        ddr_a;
   logic        ddr_b;
   logic        port_a;
   logic        port_b;
   logic        a_out;
   logic        a_oe;
   logic        b_out;
   logic        b_oe;
   logic [7:0]  top_value;
   tmwc_class_t mode_class;
   logic        ovf;
   int          bad_count;
   int          tests_run;
   int          cycles;
   // Pin table: mode, fields {a,b}, count value, {down,0,a,b}
   logic [19:0] pin_tab [15] = '{20'h0f373, 20'h0a370, 20'h05373, 20'h05370,
      20'h3f373, 20'h3f000, 20'h3a003, 20'h3a370, 20'h34372, 20'h1a37b,
      20'h1a370, 20'h1f373, 20'h1f378, 20'h7a002, 20'h7a373};
   // Overflow table: mode, count value, expected pulse
   logic [15:0] ovf_tab [10] = '{16'h0ff1, 16'h0000, 16'h1001, 16'h1ff0,
      16'h2ff1, 16'h2370, 16'h3ff1, 16'h5001, 16'h7371, 16'h7ff0};
   logic [3:0]  cls_tab [8] = '{4'h1, 4'h8, 4'h2, 4'h4, 4'h1, 4'h8, 4'h2, 4'h4};

   ////////////////////////////////////////////////////////////////////////////
   tmwc_top u_tmwc_top (
      .sys_clk            (sys_clk),
      .rst_n              (rst_n),
      .reg_addr           (reg_addr),
      .io_access          (io_access),
      .reg_wr             (reg_wr),
      .reg_rd             (reg_rd),
      .reg_wdata          (reg_wdata),
      .reg_rdata          (reg_rdata),
      .wave_mode_bit2     (wave_mode_bit2),
      .cnt                (cnt),
      .chan_a_compare_buf (cmp_a),
      .chan_b_compare_buf (cmp_b),
      .ddr_a              (ddr_a),
      .ddr_b              (ddr_b),
      .port_a             (port_a),
      .port_b             (port_b),
      .chan_a_pin_out     (a_out),
      .chan_a_pin_oe      (a_oe),
      .chan_b_pin_out     (b_out),
      .chan_b_pin_oe      (b_oe),
      .top_value          (top_value),
      .mode_class         (mode_class),
      .overflow_flag_set  (ovf)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the ceiling is well above the planned run
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access and check tasks; inputs move only on the falling edge
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      io_access = io;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask

   // Read data stands one cycle only, so it is taken right after the strobe
   task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
      @(negedge sys_clk);
      reg_addr = a;
      io_access = io;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk("read data", exp, reg_rdata);
   endtask

   task automatic setm(input logic [3:0] m, input logic [3:0] com);
      wave_mode_bit2 = m[2];
      wr(8'h44, 1'b0, {com, 2'b00, m[1:0]});
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic tick(input logic [7:0] v, input logic dn);
      @(negedge sys_clk);
      cnt.value = v;
      cnt.down = dn;
      cnt.tick = 1'b1;
      @(negedge sys_clk);
      cnt.tick = 1'b0;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_n, reg_addr, io_access, reg_wr, reg_rd, reg_wdata} = '0;
      {wave_mode_bit2, cnt, ddr_a, ddr_b, port_b} = '0;
      port_a = 1'b1;
      cmp_a = 8'h37;
      cmp_b = 8'h37;
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      rd(8'h44, 1'b0, 8'h00);
      chk("top", 8'hff, top_value);
      chk("class", 8'h01, {4'h0, mode_class});
      wr(8'h44, 1'b0, 8'hff);
      rd(8'h44, 1'b0, 8'hf3);
      rd(8'h24, 1'b1, 8'hf3);
      rd(8'h45, 1'b0, 8'h00);
      wr(8'h24, 1'b1, 8'h0c);
      rd(8'h44, 1'b0, 8'h00);
      wr(8'h44, 1'b1, 8'hc0);
      rd(8'h44, 1'b0, 8'h00);
      $display("test register done");
      // Driver enable follows the direction bit; disconnected pins show port data
      for (int i = 1; i < 4; i++)
      begin
         {ddr_a, ddr_b} = i[1:0];
         repeat (2) @(negedge sys_clk);
         chk("pin enables", i[7:0], {6'h0, a_oe, b_oe});
      end
      chk("port pins", 8'h02, {6'h0, a_out, b_out});
      $display("test pin enable done");
      for (int m = 0; m < 8; m++)
      begin
         setm(m[3:0], 4'h0);
         chk("class", {4'h0, cls_tab[m]}, {4'h0, mode_class});
         chk("top", (m == 2 || m == 5 || m == 7) ? 8'h37 : 8'hff, top_value);
      end
      $display("test mode decode done");
      // Overflow pulse lands one cycle after the tick and lasts one cycle
      foreach (ovf_tab[i])
      begin
         setm(ovf_tab[i][15:12], 4'h0);
         tick(ovf_tab[i][11:4], 1'b0);
         chk("overflow", {4'h0, ovf_tab[i][3:0]}, {7'h0, ovf});
         @(negedge sys_clk);
         chk("overflow end", 8'h00, {7'h0, ovf});
      end
      $display("test overflow done");
      // Pin level is two cycles behind the tick
      foreach (pin_tab[i])
      begin
         setm(pin_tab[i][19:16], pin_tab[i][15:12]);
         tick(pin_tab[i][11:4], pin_tab[i][3]);
         @(negedge sys_clk);
         chk("pins", {6'h0, pin_tab[i][1:0]}, {6'h0, a_out, b_out});
      end
      setm(4'h5, 4'ha);
      tick(8'h37, 1'b1);
      @(negedge sys_clk);
      chk("pins at top", 8'h00, {6'h0, a_out, b_out});
      $display("test waveform done");
      // Compare loading: at TOP in phase correct, at BOTTOM in fast, else at once
      cmp_a = 8'h40;
      repeat (3) @(negedge sys_clk);
      chk("top held", 8'h37, top_value);
      tick(8'h37, 1'b0);
      @(negedge sys_clk);
      chk("top loaded", 8'h40, top_value);
      setm(4'h7, 4'h0);
      cmp_a = 8'h20;
      repeat (3) @(negedge sys_clk);
      chk("top held", 8'h40, top_value);
      tick(8'h00, 1'b0);
      @(negedge sys_clk);
      chk("top loaded", 8'h20, top_value);
      setm(4'h2, 4'h0);
      cmp_a = 8'h11;
      repeat (3) @(negedge sys_clk);
      chk("top direct", 8'h11, top_value);
      $display("test compare load done");
      give_verdict();
   end
endmodule // tmwc_top_bench
